/* File: ssmr_pkg.sv */
`default_nettype none
package ssmr_pkg;

  localparam int unsigned ADDR_W = 12;

  // Register indices, byte address is four times the index
  localparam logic [9:0] IDX_IRQ_FLAGS   = 10'h00C;
  localparam logic [9:0] IDX_RX_STATUS   = 10'h018;
  localparam logic [9:0] IDX_TX_BUFFER   = 10'h019;
  localparam logic [9:0] IDX_RX_BUFFER   = 10'h01A;
  localparam logic [9:0] IDX_IRQ_ENABLES = 10'h08C;
  localparam logic [9:0] IDX_TX_STATUS   = 10'h098;
  localparam logic [9:0] IDX_BAUD_DIV    = 10'h099;
  localparam logic [9:0] IDX_EVT_STATUS  = 10'h100;
  localparam logic [9:0] IDX_EVT_CLEAR   = 10'h101;
  localparam logic [9:0] IDX_EVT_ENABLE  = 10'h102;

  // Field positions
  localparam int unsigned POS_RECEIVE_FLAG       = 5;
  localparam int unsigned POS_RECEIVE_IRQ_ENABLE = 5;
  localparam int unsigned POS_SERIAL_PORT_ENABLE = 7;
  localparam int unsigned POS_NINE_BIT_SELECT    = 6;
  localparam int unsigned POS_SINGLE_RECEIVE     = 5;
  localparam int unsigned POS_CONT_RECEIVE       = 4;
  localparam int unsigned POS_OVERRUN_ERROR      = 1;
  localparam int unsigned POS_NINTH_BIT          = 0;
  localparam int unsigned POS_CLOCK_MASTER       = 7;
  localparam int unsigned POS_SYNC_MODE          = 4;
  localparam int unsigned POS_SHIFT_EMPTY        = 1;
  localparam int unsigned POS_EVT_WORD           = 0;
  localparam int unsigned POS_EVT_OVERRUN        = 1;

  // Reset values and masks
  localparam logic [7:0] RST_RX_CTRL     = 8'h00;
  localparam logic [7:0] RST_TX_STATUS   = 8'h02;
  localparam logic [7:0] RST_TX_BUFFER   = 8'h00;
  localparam logic [7:0] RST_IRQ_ENABLES = 8'h00;
  localparam logic [7:0] RST_BAUD_DIV    = 8'h00;
  localparam logic [1:0] RST_EVT         = 2'h0;
  localparam logic [7:0] MASK_TX_STATUS  = 8'hF5;

  // Word lengths, as last bit index
  localparam logic [3:0] LAST_BIT_SHORT = 4'h7;
  localparam logic [3:0] LAST_BIT_LONG  = 4'h8;
  localparam logic [1:0] FIFO_DEPTH     = 2'h2;

  typedef struct packed {
    logic       ninth;
    logic [7:0] data;
  } ssmr_entry_type;

  typedef struct packed {
    logic port_enable;
    logic nine_bit;
    logic single_rx;
    logic cont_rx;
  } ssmr_ctrl_type;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_HIGH,
    ST_LOW
  } ssmr_state_type;

endpackage
`default_nettype wire

/* File: ssmr_receiver.sv */
`timescale 1ns/1ps
`default_nettype none
module ssmr_receiver
  import ssmr_pkg::*;
(
  // Clock and reset
  input  wire logic              I_CLK,
  input  wire logic              I_RST_N,
  // APB slave
  input  wire logic              I_PSEL,
  input  wire logic              I_PENABLE,
  input  wire logic              I_PWRITE,
  input  wire logic [ADDR_W-1:0] I_PADDR,
  input  wire logic [31:0]       I_PWDATA,
  output var  logic [31:0]       O_PRDATA,
  output var  logic              O_PREADY,
  output var  logic              O_PSLVERR,
  // Serial data pin
  input  wire logic              I_DT_I,
  output var  logic              O_DT_O,
  output var  logic              O_DT_OE,
  // Shift clock pin
  output var  logic              O_CK_O,
  output var  logic              O_CK_OE,
  // Interrupt
  output var  logic              O_IRQ
);

  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [9:0] idx);
    reg_hit = (addr == {idx, 2'b00});
  endfunction

  function automatic logic reg_mapped(input logic [ADDR_W-1:0] addr);
    reg_mapped = reg_hit(addr, IDX_IRQ_FLAGS) | reg_hit(addr, IDX_RX_STATUS) |
                 reg_hit(addr, IDX_TX_BUFFER) | reg_hit(addr, IDX_RX_BUFFER) |
                 reg_hit(addr, IDX_IRQ_ENABLES) | reg_hit(addr, IDX_TX_STATUS) |
                 reg_hit(addr, IDX_BAUD_DIV) | reg_hit(addr, IDX_EVT_STATUS) |
                 reg_hit(addr, IDX_EVT_CLEAR) | reg_hit(addr, IDX_EVT_ENABLE);
  endfunction

  ssmr_ctrl_type  ctrl_reg;
  logic [7:0]     tx_status_reg;
  logic [7:0]     tx_buffer_reg;
  logic [7:0]     irq_enables_reg;
  logic [7:0]     baud_div_reg;
  logic [1:0]     evt_status_reg;
  logic [1:0]     evt_enable_reg;
  logic           overrun_error_reg;
  logic [31:0]    prdata_reg;
  logic           dt_meta_reg;
  logic           dt_sync_reg;
  ssmr_state_type state_reg;
  logic [7:0]     div_cnt_reg;
  logic [3:0]     bit_cnt_reg;
  logic [8:0]     shift_reg;
  ssmr_entry_type fifo_mem_reg [FIFO_DEPTH];
  logic           wr_ptr_reg;
  logic           rd_ptr_reg;
  logic [1:0]     count_reg;

  logic           wr_access;
  logic           rd_access;
  logic           go;
  logic           half_end;
  logic           sample_evt;
  logic           word_done;
  logic [3:0]     last_bit;
  logic [8:0]     shift_next;
  ssmr_entry_type word_new;
  logic           push;
  logic           pop;
  logic           overrun_evt;
  logic           clr_overrun_error;
  logic           receive_flag;
  logic [1:0]     evt_set;
  logic [1:0]     evt_clr;
  logic [31:0]    read_word;
  ssmr_entry_type head;

  // APB access phase, one wait-free access cycle after setup
  assign wr_access = I_PSEL & I_PENABLE & I_PWRITE;
  assign rd_access = I_PSEL & I_PENABLE & ~I_PWRITE;
  assign O_PREADY  = I_PSEL & I_PENABLE;
  assign O_PSLVERR = I_PSEL & I_PENABLE & ~reg_mapped(I_PADDR);
  assign O_PRDATA  = prdata_reg;

  // Receive pin only, data line never driven here
  assign O_DT_O  = 1'b0;
  assign O_DT_OE = 1'b0;

  assign head = fifo_mem_reg[rd_ptr_reg];
  assign receive_flag = (count_reg != 2'h0);

  assign go = ctrl_reg.port_enable & tx_status_reg[POS_SYNC_MODE] & tx_status_reg[POS_CLOCK_MASTER] &
              (ctrl_reg.single_rx | ctrl_reg.cont_rx) & ~overrun_error_reg;

  assign half_end   = (div_cnt_reg == baud_div_reg);
  assign sample_evt = (state_reg == ST_HIGH) & half_end;
  assign last_bit   = ctrl_reg.nine_bit ? LAST_BIT_LONG : LAST_BIT_SHORT;
  assign word_done  = sample_evt & (bit_cnt_reg == last_bit);
  assign shift_next = {dt_sync_reg, shift_reg[8:1]};

  // Align the word, LSB first, ninth bit last
  always_comb
  begin
    if (ctrl_reg.nine_bit)
    begin
      word_new.data  = shift_next[7:0];
      word_new.ninth = shift_next[8];
    end
    else
    begin
      word_new.data  = shift_next[8:1];
      word_new.ninth = 1'b0;
    end
  end

  assign push        = word_done & (count_reg != FIFO_DEPTH) & ~overrun_error_reg;
  assign overrun_evt = word_done & (count_reg == FIFO_DEPTH) & ~overrun_error_reg;
  assign pop         = rd_access & reg_hit(I_PADDR, IDX_RX_BUFFER) & receive_flag;
  assign clr_overrun_error    = wr_access & reg_hit(I_PADDR, IDX_RX_STATUS) & ~I_PWDATA[POS_CONT_RECEIVE];

  assign evt_set = {overrun_evt, push};
  assign evt_clr = (wr_access & reg_hit(I_PADDR, IDX_EVT_CLEAR)) ? I_PWDATA[1:0] : 2'h0;

  assign O_IRQ = (receive_flag & irq_enables_reg[POS_RECEIVE_IRQ_ENABLE]) | (|(evt_status_reg & evt_enable_reg));

  // Shift clock driven only while a word is in progress
  assign O_CK_O  = (state_reg == ST_HIGH);
  assign O_CK_OE = (state_reg != ST_IDLE);

  // Two-stage synchroniser on the data pin
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      dt_meta_reg <= 1'b0;
      dt_sync_reg <= 1'b0;
    end
    else
    begin
      dt_meta_reg <= I_DT_I;
      dt_sync_reg <= dt_meta_reg;
    end
  end

  // Receive control register
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      ctrl_reg <= ssmr_ctrl_type'(RST_RX_CTRL[7:4]);
    end
    else if (wr_access && reg_hit(I_PADDR, IDX_RX_STATUS))
    begin
      ctrl_reg.port_enable <= I_PWDATA[POS_SERIAL_PORT_ENABLE];
      ctrl_reg.nine_bit    <= I_PWDATA[POS_NINE_BIT_SELECT];
      ctrl_reg.single_rx   <= I_PWDATA[POS_SINGLE_RECEIVE];
      ctrl_reg.cont_rx     <= I_PWDATA[POS_CONT_RECEIVE];
    end
    else if (word_done && !ctrl_reg.cont_rx)
    begin
      ctrl_reg.single_rx <= 1'b0;
    end
  end

  // Overrun error, set wins over clear
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      overrun_error_reg <= 1'b0;
    end
    else if (overrun_evt)
    begin
      overrun_error_reg <= 1'b1;
    end
    else if (clr_overrun_error)
    begin
      overrun_error_reg <= 1'b0;
    end
  end

  // Mode, buffer and divisor registers
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      tx_status_reg   <= RST_TX_STATUS;
      tx_buffer_reg   <= RST_TX_BUFFER;
      irq_enables_reg <= RST_IRQ_ENABLES;
      baud_div_reg    <= RST_BAUD_DIV;
      evt_enable_reg  <= RST_EVT;
    end
    else if (wr_access)
    begin
      if (reg_hit(I_PADDR, IDX_TX_STATUS))
      begin
        tx_status_reg <= I_PWDATA[7:0] & MASK_TX_STATUS;
      end
      if (reg_hit(I_PADDR, IDX_TX_BUFFER))
      begin
        tx_buffer_reg <= I_PWDATA[7:0];
      end
      if (reg_hit(I_PADDR, IDX_IRQ_ENABLES))
      begin
        irq_enables_reg <= I_PWDATA[7:0];
      end
      if (reg_hit(I_PADDR, IDX_BAUD_DIV))
      begin
        baud_div_reg <= I_PWDATA[7:0];
      end
      if (reg_hit(I_PADDR, IDX_EVT_ENABLE))
      begin
        evt_enable_reg <= I_PWDATA[1:0];
      end
    end
  end

  // Sticky event status, set wins over clear
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      evt_status_reg <= RST_EVT;
    end
    else
    begin
      evt_status_reg <= (evt_status_reg & ~evt_clr) | evt_set;
    end
  end

  // Shift clock generator and bit sampler
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      state_reg   <= ST_IDLE;
      div_cnt_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      shift_reg   <= 9'h000;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          div_cnt_reg <= 8'h00;
          bit_cnt_reg <= 4'h0;
          if (go)
          begin
            state_reg <= ST_HIGH;
          end
        end
        ST_HIGH:
        begin
          if (half_end)
          begin
            div_cnt_reg <= 8'h00;
            shift_reg   <= shift_next;
            state_reg   <= ST_LOW;
            bit_cnt_reg <= word_done ? 4'h0 : bit_cnt_reg + 4'h1;
          end
          else
          begin
            div_cnt_reg <= div_cnt_reg + 8'h01;
          end
        end
        ST_LOW:
        begin
          if (half_end)
          begin
            div_cnt_reg <= 8'h00;
            if (go)
            begin
              state_reg <= ST_HIGH;
            end
            else
            begin
              state_reg   <= ST_IDLE;
              bit_cnt_reg <= 4'h0;
            end
          end
          else
          begin
            div_cnt_reg <= div_cnt_reg + 8'h01;
          end
        end
        default:
        begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Two-entry receive FIFO with the ninth bit stored per word
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop)
      begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      if (push && !pop)
      begin
        count_reg <= count_reg + 2'h1;
      end
      else if (pop && !push)
      begin
        count_reg <= count_reg - 2'h1;
      end
    end
  end

  generate
    for (genvar g = 0; g < FIFO_DEPTH; g++)
    begin : g_fifo
      always_ff @(posedge I_CLK)
      begin
        if (!I_RST_N)
        begin
          fifo_mem_reg[g] <= ssmr_entry_type'(9'h000);
        end
        else if (push && (wr_ptr_reg == 1'(g)))
        begin
          fifo_mem_reg[g] <= word_new;
        end
      end
    end
  endgenerate

  // Read mux, captured in the setup cycle
  always_comb
  begin
    read_word = 32'h0000_0000;
    if (reg_hit(I_PADDR, IDX_IRQ_FLAGS))
    begin
      read_word[POS_RECEIVE_FLAG] = receive_flag;
    end
    else if (reg_hit(I_PADDR, IDX_RX_STATUS))
    begin
      read_word[7:4]               = ctrl_reg;
      read_word[POS_OVERRUN_ERROR] = overrun_error_reg;
      read_word[POS_NINTH_BIT]     = receive_flag & head.ninth;
    end
    else if (reg_hit(I_PADDR, IDX_RX_BUFFER))
    begin
      read_word[7:0] = receive_flag ? head.data : 8'h00;
    end
    else if (reg_hit(I_PADDR, IDX_IRQ_ENABLES))
    begin
      read_word[7:0] = irq_enables_reg;
    end
    else if (reg_hit(I_PADDR, IDX_TX_STATUS))
    begin
      read_word[7:0]             = tx_status_reg;
      read_word[POS_SHIFT_EMPTY] = 1'b1;
    end
    else if (reg_hit(I_PADDR, IDX_BAUD_DIV))
    begin
      read_word[7:0] = baud_div_reg;
    end
    else if (reg_hit(I_PADDR, IDX_EVT_STATUS))
    begin
      read_word[1:0] = evt_status_reg;
    end
    else if (reg_hit(I_PADDR, IDX_EVT_ENABLE))
    begin
      read_word[1:0] = evt_enable_reg;
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      prdata_reg <= 32'h0000_0000;
    end
    else if (I_PSEL && !I_PENABLE && !I_PWRITE)
    begin
      prdata_reg <= read_word;
    end
  end

  // Checks
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_N);

  sequence s_word_end;
    word_done && !ctrl_reg.cont_rx;
  endsequence

  sequence s_clock_stops;
    !ctrl_reg.single_rx ##[1:300] (state_reg == ST_IDLE);
  endsequence

  property p_start_clock;
    (state_reg == ST_IDLE) && go |=> O_CK_O && O_CK_OE;
  endproperty
  a_start_clock: assert property (p_start_clock) else $error("shift clock did not start");

  property p_fall_sample;
    sample_evt && !word_done |=> !O_CK_O && (bit_cnt_reg == $past(bit_cnt_reg) + 4'h1);
  endproperty
  a_fall_sample: assert property (p_fall_sample) else $error("bit not taken at falling edge");

  property p_single_stop;
    s_word_end ##0 !(wr_access && reg_hit(I_PADDR, IDX_RX_STATUS)) |=> s_clock_stops;
  endproperty
  a_single_stop: assert property (p_single_stop) else $error("single reception did not stop");

  property p_push_flag;
    push |=> receive_flag && (evt_status_reg[POS_EVT_WORD]);
  endproperty
  a_push_flag: assert property (p_push_flag) else $error("receive flag not set after transfer");

  property p_irq_gate;
    receive_flag && irq_enables_reg[POS_RECEIVE_IRQ_ENABLE] |-> O_IRQ;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("enabled receive flag without interrupt");

  property p_flag_clear;
    pop && (count_reg == 2'h1) && !push |=> !receive_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("receive flag stuck after last read");

  property p_overrun;
    overrun_evt |=> overrun_error_reg && (wr_ptr_reg == $past(wr_ptr_reg));
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged or word stored");

  property p_overrun_error_clear;
    clr_overrun_error && !overrun_evt |=> !overrun_error_reg;
  endproperty
  a_overrun_error_clear: assert property (p_overrun_error_clear) else $error("overrun not cleared with enable");

  property p_overrun_error_block;
    overrun_error_reg |-> !push && !go;
  endproperty
  a_overrun_error_block: assert property (p_overrun_error_block) else $error("transfer during overrun");

  property p_word_length;
    word_done |-> (bit_cnt_reg == (ctrl_reg.nine_bit ? 4'h8 : 4'h7));
  endproperty
  a_word_length: assert property (p_word_length) else $error("wrong word length");

  property p_clock_idle;
    (state_reg == ST_IDLE) |-> !O_CK_OE && !O_CK_O;
  endproperty
  a_clock_idle: assert property (p_clock_idle) else $error("shift clock driven while idle");

endmodule
`default_nettype wire

/* File: ssmr_receiver_test.sv */
`timescale 1ns/1ps
`default_nettype none
module ssmr_receiver_test
  import ssmr_pkg::*;
;
  logic              clk;
  logic              rst_n;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              dt;
  logic              dt_o;
  logic              dt_oe;
  logic              ck;
  logic              ck_oe;
  logic              irq;
  logic              nine;
  logic [31:0]       rdata;
  logic              perr;
  logic [7:0]        cw [3] = '{8'h5A, 8'h81, 8'h7E};
  int                errors;
  int                samples_checked;

  ssmr_receiver dut (
    .I_CLK     (clk),
    .I_RST_N   (rst_n),
    .I_PSEL    (psel),
    .I_PENABLE (penable),
    .I_PWRITE  (pwrite),
    .I_PADDR   (paddr),
    .I_PWDATA  (pwdata),
    .O_PRDATA  (prdata),
    .O_PREADY  (pready),
    .O_PSLVERR (pslverr),
    .I_DT_I    (dt),
    .O_DT_O    (dt_o),
    .O_DT_OE   (dt_oe),
    .O_CK_O    (ck),
    .O_CK_OE   (ck_oe),
    .O_IRQ     (irq)
  );

  ssmr_slave_model slave (
    .i_ck    (ck),
    .i_ck_oe (ck_oe),
    .i_nine  (nine),
    .o_dt    (dt)
  );

  always #50 clk = ~clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer, held until pready
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h00_0000, wd};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rdata = prdata;
    perr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] idx, input logic [7:0] m, input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    chk({rdata[31:8], rdata[7:0] & m}, 32'(e));
  endtask

  task automatic poll(input logic [9:0] idx, input logic [7:0] m, input logic [7:0] e);
    int n;
    n = 0;
    apb(1'b0, idx, 8'h00);
    while ((rdata[7:0] & m) !== e && n < 300)
    begin
      apb(1'b0, idx, 8'h00);
      n++;
    end
    chk(32'(rdata[7:0] & m), 32'(e));
  endtask

  task automatic wrap_up;
    $display("Checks made: %0d, mismatches: %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    wrap_up();
  end

  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    nine = 1'b0;
    errors = 0;
    samples_checked = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values and an unmapped place
    rd(IDX_RX_STATUS, 8'hFE, 8'h00);
    rd(IDX_TX_STATUS, 8'hFF, 8'h02);
    rd(IDX_BAUD_DIV, 8'hFF, 8'h00);
    rd(IDX_IRQ_ENABLES, 8'hFF, 8'h00);
    rd(IDX_IRQ_FLAGS, 8'hFF, 8'h00);
    rd(IDX_EVT_STATUS, 8'hFF, 8'h00);
    apb(1'b0, 10'h050, 8'h00);
    chk(32'(perr), 32'h0000_0001);
    chk(rdata, 32'h0000_0000);
    @(negedge clk);
    chk(32'({dt_o, dt_oe}), 32'h0000_0000);
    $display("Test reset values done");
    // Set up with both enables clear; half bit of four clocks
    apb(1'b1, IDX_BAUD_DIV, 8'h03);
    apb(1'b1, IDX_TX_STATUS, 8'h90);
    apb(1'b1, IDX_RX_STATUS, 8'h80);
    apb(1'b1, IDX_IRQ_ENABLES, 8'h20);
    rd(IDX_TX_STATUS, 8'hFF, 8'h92);
    rd(IDX_BAUD_DIV, 8'hFF, 8'h03);
    @(negedge clk);
    chk(32'(ck_oe), 32'h0000_0000);
    // Single word with a second one waiting at the slave
    slave.q.push_back(9'h0A5);
    slave.q.push_back(9'h05A);
    apb(1'b1, IDX_RX_STATUS, 8'hA0);
    repeat (2) @(posedge clk);
    chk(32'(ck_oe), 32'h0000_0001);
    poll(IDX_IRQ_FLAGS, 8'h20, 8'h20);
    @(negedge clk);
    chk(32'(irq), 32'h0000_0001);
    apb(1'b1, IDX_IRQ_FLAGS, 8'h00);
    rd(IDX_IRQ_FLAGS, 8'h20, 8'h20);
    rd(IDX_RX_STATUS, 8'hFE, 8'h80);
    rd(IDX_RX_BUFFER, 8'hFF, 8'hA5);
    @(negedge clk);
    chk(32'(irq), 32'h0000_0000);
    rd(IDX_IRQ_FLAGS, 8'h20, 8'h00);
    repeat (150) @(posedge clk);
    chk(32'(slave.q.size()), 32'h0000_0001);
    chk(32'(ck_oe), 32'h0000_0000);
    slave.q.delete();
    $display("Test single word done");
    // Both enables, nine bits, FIFO left full until overrun
    nine = 1'b1;
    slave.q.push_back(9'h1C3);
    slave.q.push_back(9'h03C);
    slave.q.push_back(9'h155);
    slave.q.push_back(9'h0AA);
    apb(1'b1, IDX_RX_STATUS, 8'hF0);
    poll(IDX_RX_STATUS, 8'h02, 8'h02);
    repeat (100) @(posedge clk);
    rd(IDX_RX_STATUS, 8'hD3, 8'hD3);
    rd(IDX_RX_BUFFER, 8'hFF, 8'hC3);
    rd(IDX_RX_STATUS, 8'h01, 8'h00);
    rd(IDX_RX_BUFFER, 8'hFF, 8'h3C);
    rd(IDX_RX_BUFFER, 8'hFF, 8'h00);
    rd(IDX_IRQ_FLAGS, 8'h20, 8'h00);
    rd(IDX_RX_STATUS, 8'h02, 8'h02);
    apb(1'b1, IDX_RX_STATUS, 8'hC0);
    rd(IDX_RX_STATUS, 8'h32, 8'h00);
    // Sticky events, enable and clear
    rd(IDX_EVT_STATUS, 8'h03, 8'h03);
    apb(1'b1, IDX_EVT_ENABLE, 8'h02);
    @(negedge clk);
    chk(32'(irq), 32'h0000_0001);
    apb(1'b1, IDX_EVT_CLEAR, 8'h02);
    @(negedge clk);
    chk(32'(irq), 32'h0000_0000);
    rd(IDX_EVT_STATUS, 8'h03, 8'h01);
    apb(1'b1, IDX_EVT_CLEAR, 8'h01);
    apb(1'b1, IDX_EVT_ENABLE, 8'h00);
    slave.q.delete();
    $display("Test overrun done");
    // Continuous eight-bit words with the interrupt masked
    nine = 1'b0;
    apb(1'b1, IDX_IRQ_ENABLES, 8'h00);
    for (int k = 0; k < 3; k++)
      slave.q.push_back({1'b0, cw[k]});
    apb(1'b1, IDX_RX_STATUS, 8'h90);
    for (int k = 0; k < 3; k++)
    begin
      poll(IDX_IRQ_FLAGS, 8'h20, 8'h20);
      @(negedge clk);
      chk(32'(irq), 32'h0000_0000);
      rd(IDX_RX_BUFFER, 8'hFF, cw[k]);
    end
    apb(1'b1, IDX_RX_STATUS, 8'h80);
    repeat (100) @(posedge clk);
    chk(32'(ck_oe), 32'h0000_0000);
    rd(IDX_RX_BUFFER, 8'hFF, 8'h00);
    $display("Test continuous done");
    wrap_up();
  end
endmodule
`default_nettype wire

/* File: ssmr_slave_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ssmr_slave_model (
  // Shift clock from the receiver
  input  wire logic i_ck,
  input  wire logic i_ck_oe,
  // Word length select
  input  wire logic i_nine,
  // Data pin toward the receiver
  output var  logic o_dt
);
  logic [8:0] q [$];
  logic [8:0] word = 9'h000;
  int         bitn = 0;

  initial o_dt = 1'b0;

  // Next bit appears at the rising shift clock, steady until after the falling edge
  always @(posedge i_ck)
  begin
    if (bitn == 0)
      word = (q.size() != 0) ? q.pop_front() : 9'h0F0;
    o_dt = word[bitn];
    bitn = (bitn == (i_nine ? 8 : 7)) ? 0 : bitn + 1;
  end

  // Hold time over: show the inverse so a late sample is caught
  always @(negedge i_ck)
    o_dt <= #20 ~o_dt;

  // Aborted word starts over
  always @(negedge i_ck_oe)
    bitn = 0;
endmodule
`default_nettype wire
